// file: rcd_ref_clock_out.sv
`timescale 1ns/100ps
// Behaviour
// - with the enable bit set the divided clock drives the output pin, with it clear the pin is disabled.
// - the four divisor bits divide the base clock by two to the power of their value, zero passing it undivided.
// - with the source bit set the primary oscillator is the base clock.
// - with the source bit clear the system clock is the base clock and follows every clock switch.
// - with the run-in-sleep and source bits set and a primary oscillator mode configured the output keeps running in sleep.
// - with the run-in-sleep bit clear the output stops on sleep entry.
// - the output runs in sleep only with run-in-sleep and source set and a primary oscillator mode configured.
// - without the source bit the primary oscillator is powered down on sleep entry.
// - the crystal runs in sleep only when the oscillator configuration enables it.
// - the output works in every oscillator configuration while awake.
// - bit 14 and the low byte read as zero and ignore writes.
module rcd_ref_clock_out (
  // clock and reset
  input  wire logic                        ref_clk,
  input  wire logic                        sys_rst,
  // wishbone slave
  input  wire rcd_pkg::rcd_wb_req_t        wbReq,
  output rcd_pkg::rcd_wb_rsp_t             wbRsp,
  // base clock levels
  input  wire logic                        sysClkLevel,
  input  wire logic                        primaryClkLevel,
  // power and oscillator configuration
  input  wire logic                        sleepRequest,
  input  wire logic [2:0]                  oscConfig,
  // reference pin
  output logic                             refClockPin,
  output logic                             refClockOe,
  // primary oscillator control
  output logic                             primaryOscEnable
);
  import rcd_pkg::*;

  typedef struct packed {
    rcd_ctrl_t        ctrl;
    rcd_power_t       power;
    logic             ack;
    logic [31:0]      rdData;
    logic             pin;
    logic             oe;
    logic             primEn;
  } rcd_top_state_t;

  rcd_top_state_t stateReg;
  rcd_top_state_t stateNext;

  // base clock edges
  logic sysRise;
  logic primaryRise;
  logic baseTick;
  logic baseLevel;
  logic divLevel;
  logic divHold;

  // bus decode
  logic        busTake;
  logic        busCommit;
  logic        hitCtrl;
  logic        hitStatus;
  logic [15:0] ctrlWord;
  logic [15:0] writeWord;
  logic [15:0] laneMask;
  logic [31:0] readWord;
  logic [31:0] statusWord;

  // sleep decision
  logic       primaryMode;
  logic       keepInSleep;
  rcd_power_t powerNext;

  rcd_edge_detect u_sys_edge (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .level   (sysClkLevel),
    .rise    (sysRise)
  );

  rcd_edge_detect u_primary_edge (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .level   (primaryClkLevel),
    .rise    (primaryRise)
  );

  always_comb begin
    if (stateReg.ctrl.refSourceSelect) begin
      baseTick  = primaryRise;
      baseLevel = primaryClkLevel;
    end else begin
      baseTick  = sysRise;
      baseLevel = sysClkLevel;
    end
  end

  assign divHold = ~stateReg.ctrl.refOutEnable | (stateReg.power == PWR_SLEEP_STOP);

  rcd_divider #(
    .SEL_W (DIV_W)
  ) u_divider (
    .ref_clk       (ref_clk),
    .sys_rst       (sys_rst),
    .baseTick      (baseTick),
    .baseLevel     (baseLevel),
    .hold          (divHold),
    .divisorSelect (stateReg.ctrl.refDivisorSelect),
    .divLevel      (divLevel)
  );

  // oscillator configuration check
  always_comb begin
    case (oscConfig)
      EXTERNAL_CLOCK_MODE:     primaryMode = 1'b1;
      STANDARD_CRYSTAL_MODE:   primaryMode = 1'b1;
      HIGH_SPEED_CRYSTAL_MODE: primaryMode = 1'b1;
      default:                 primaryMode = 1'b0;
    endcase
  end

  assign keepInSleep = stateReg.ctrl.refRunInSleep & stateReg.ctrl.refSourceSelect & primaryMode;

  // power state
  always_comb begin
    powerNext = stateReg.power;
    case (stateReg.power)
      PWR_AWAKE: begin
        if (sleepRequest) begin
          if (keepInSleep) begin
            powerNext = PWR_SLEEP_RUN;
          end else begin
            powerNext = PWR_SLEEP_STOP;
          end
        end
      end
      PWR_SLEEP_RUN: begin
        if (!sleepRequest) begin
          powerNext = PWR_AWAKE;
        end else if (!keepInSleep) begin
          powerNext = PWR_SLEEP_STOP;
        end
      end
      PWR_SLEEP_STOP: begin
        if (!sleepRequest) begin
          powerNext = PWR_AWAKE;
        end
      end
      default: begin
        powerNext = PWR_AWAKE;
      end
    endcase
  end

  // register decode
  assign busTake   = wbReq.cyc & wbReq.stb & ~stateReg.ack;
  assign busCommit = wbReq.cyc & wbReq.stb & stateReg.ack & wbReq.we;
  assign hitCtrl   = (wbReq.adr == CTRL_OFFSET);
  assign hitStatus = (wbReq.adr == STATUS_OFFSET);
  assign ctrlWord  = stateReg.ctrl;
  assign laneMask  = {{8{wbReq.sel[1]}}, {8{wbReq.sel[0]}}};
  assign writeWord = (ctrlWord & ~(laneMask & CTRL_WRITE_MASK))
                   | (wbReq.dat[15:0] & laneMask & CTRL_WRITE_MASK);

  always_comb begin
    statusWord                   = STATUS_RESET;
    statusWord[STS_OE_BIT]       = stateReg.oe;
    statusWord[STS_LEVEL_BIT]    = stateReg.pin;
    statusWord[STS_SLEEP_BIT]    = (stateReg.power != PWR_AWAKE);
    statusWord[STS_SLEEPRUN_BIT] = (stateReg.power == PWR_SLEEP_RUN);
    statusWord[STS_PRIMEN_BIT]   = stateReg.primEn;
    statusWord[STS_PRIMSRC_BIT]  = stateReg.ctrl.refSourceSelect;
  end

  always_comb begin
    readWord = 32'h0000_0000;
    if (hitCtrl) begin
      readWord = {16'h0000, ctrlWord & CTRL_WRITE_MASK};
    end else if (hitStatus) begin
      readWord = statusWord;
    end
  end

  // next state
  always_comb begin
    stateNext       = stateReg;
    stateNext.power = powerNext;
    stateNext.ack   = busTake;
    if (busTake) begin
      stateNext.rdData = wbReq.we ? 32'h0000_0000 : readWord;
    end
    if (busCommit && hitCtrl) begin
      stateNext.ctrl = rcd_ctrl_t'(writeWord);
    end
    stateNext.ctrl.reserved14 = 1'b0;
    stateNext.ctrl.lowByte    = 8'h00;

    // pin drive
    stateNext.oe = stateReg.ctrl.refOutEnable;
    if (stateReg.ctrl.refOutEnable && (stateReg.power != PWR_SLEEP_STOP)) begin
      stateNext.pin = divLevel;
    end else begin
      stateNext.pin = 1'b0;
    end

    // primary oscillator power
    if (powerNext == PWR_AWAKE) begin
      stateNext.primEn = primaryMode;
    end else if (powerNext == PWR_SLEEP_RUN) begin
      stateNext.primEn = primaryMode;
    end else begin
      stateNext.primEn = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      stateReg.ctrl   <= rcd_ctrl_t'(CTRL_RESET);
      stateReg.power  <= PWR_AWAKE;
      stateReg.ack    <= 1'b0;
      stateReg.rdData <= 32'h0000_0000;
      stateReg.pin    <= 1'b0;
      stateReg.oe     <= 1'b0;
      stateReg.primEn <= 1'b0;
    end else begin
      stateReg <= stateNext;
    end
  end

  assign wbRsp.ack        = stateReg.ack;
  assign wbRsp.dat        = stateReg.rdData;
  assign refClockPin      = stateReg.pin;
  assign refClockOe       = stateReg.oe;
  assign primaryOscEnable = stateReg.primEn;

endmodule // rcd_ref_clock_out

// file: rcd_pkg.sv
package rcd_pkg;

  // clock rate of the register and divider logic
  localparam int unsigned REF_CLK_HZ        = 40_000_000;
  localparam int unsigned REF_CLK_PERIOD_NS = 25;

  // register offsets (byte addresses, one aligned word each)
  localparam int unsigned  ADR_W           = 8;
  localparam logic [7:0]   CTRL_OFFSET     = 8'h00;
  localparam logic [7:0]   STATUS_OFFSET   = 8'h04;

  // control register field positions
  localparam int unsigned  CTRL_W          = 16;
  localparam int unsigned  ENABLE_BIT      = 15;
  localparam int unsigned  RESERVED_BIT    = 14;
  localparam int unsigned  RUN_SLEEP_BIT   = 13;
  localparam int unsigned  SOURCE_BIT      = 12;
  localparam int unsigned  DIV_LSB         = 8;
  localparam int unsigned  DIV_W           = 4;

  // values after reset and writable bits
  localparam logic [15:0]  CTRL_RESET      = 16'h0000;
  localparam logic [15:0]  CTRL_WRITE_MASK = 16'hbf00;
  localparam logic [31:0]  STATUS_RESET    = 32'h0000_0000;

  // status register field positions
  localparam int unsigned  STS_OE_BIT      = 0;
  localparam int unsigned  STS_LEVEL_BIT   = 1;
  localparam int unsigned  STS_SLEEP_BIT   = 2;
  localparam int unsigned  STS_SLEEPRUN_BIT = 3;
  localparam int unsigned  STS_PRIMEN_BIT  = 4;
  localparam int unsigned  STS_PRIMSRC_BIT = 5;

  // oscillator configuration codes
  localparam int unsigned  OSC_CFG_W                = 3;
  localparam logic [2:0]   EXTERNAL_CLOCK_MODE      = 3'h0;
  localparam logic [2:0]   STANDARD_CRYSTAL_MODE    = 3'h1;
  localparam logic [2:0]   HIGH_SPEED_CRYSTAL_MODE  = 3'h2;

  typedef struct packed {
    logic             refOutEnable;
    logic             reserved14;
    logic             refRunInSleep;
    logic             refSourceSelect;
    logic [3:0]       refDivisorSelect;
    logic [7:0]       lowByte;
  } rcd_ctrl_t;

  typedef struct packed {
    logic             cyc;
    logic             stb;
    logic             we;
    logic [3:0]       sel;
    logic [7:0]       adr;
    logic [31:0]      dat;
  } rcd_wb_req_t;

  typedef struct packed {
    logic             ack;
    logic [31:0]      dat;
  } rcd_wb_rsp_t;

  typedef enum logic [1:0] {
    PWR_AWAKE,
    PWR_SLEEP_RUN,
    PWR_SLEEP_STOP
  } rcd_power_t;

endpackage

// file: rcd_edge_detect.sv
`timescale 1ns/100ps
module rcd_edge_detect (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  // sampled level
  input  wire logic level,
  output logic      rise
);
  import rcd_pkg::*;

  typedef struct packed {
    logic prevLevel;
  } rcd_edge_state_t;

  rcd_edge_state_t stateReg;
  rcd_edge_state_t stateNext;

  always_comb begin
    stateNext           = stateReg;
    stateNext.prevLevel = level;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      stateReg <= '0;
    end else begin
      stateReg <= stateNext;
    end
  end

  assign rise = level & ~stateReg.prevLevel;

endmodule // rcd_edge_detect

// file: rcd_divider.sv
`timescale 1ns/100ps
module rcd_divider #(
  parameter int unsigned SEL_W = 4
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             sys_rst,
  // base clock as level and rising-edge pulse
  input  wire logic             baseTick,
  input  wire logic             baseLevel,
  // control
  input  wire logic             hold,
  input  wire logic [SEL_W-1:0] divisorSelect,
  // divided level
  output logic                  divLevel
);
  import rcd_pkg::*;

  localparam int unsigned CNT_W = (2 ** SEL_W) - 1;

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic             level;
    logic [SEL_W-1:0] prevSelect;
  } rcd_div_state_t;

  rcd_div_state_t   stateReg;
  rcd_div_state_t   stateNext;
  logic [CNT_W-1:0] lastCount;

  always_comb begin
    lastCount = '0;
    if (divisorSelect != '0) begin
      lastCount = CNT_W'((32'h1 << (divisorSelect - SEL_W'(1))) - 32'h1);
    end
    stateNext            = stateReg;
    stateNext.prevSelect = divisorSelect;
    if (hold || (divisorSelect != stateReg.prevSelect)) begin
      stateNext.count = '0;
      stateNext.level = 1'b0;
    end else if (divisorSelect == '0) begin
      stateNext.level = baseLevel;
    end else if (baseTick) begin
      if (stateReg.count == lastCount) begin
        stateNext.count = '0;
        stateNext.level = ~stateReg.level;
      end else begin
        stateNext.count = stateReg.count + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      stateReg <= '0;
    end else begin
      stateReg <= stateNext;
    end
  end

  assign divLevel = stateReg.level;

endmodule // rcd_divider

// file: rcd_ref_clock_out_props.sv
`timescale 1ns/100ps
module rcd_ref_clock_out_props (
  // clock and reset
  input wire logic                 ref_clk,
  input wire logic                 sys_rst,
  // bus
  input wire rcd_pkg::rcd_wb_req_t wbReq,
  input wire rcd_pkg::rcd_wb_rsp_t wbRsp,
  // base clocks and power
  input wire logic                 sysClkLevel,
  input wire logic                 primaryClkLevel,
  input wire logic                 sleepRequest,
  input wire logic [2:0]           oscConfig,
  // outputs
  input wire logic                 refClockPin,
  input wire logic                 refClockOe,
  input wire logic                 primaryOscEnable
);
  import rcd_pkg::*;
  logic [7:0] ctrlShadow_reg;
  logic       shEn;
  logic       baseLevel;
  assign shEn = ctrlShadow_reg[7];
  assign baseLevel = ctrlShadow_reg[4] ? primaryClkLevel : sysClkLevel;
  // mirror of control bits 15:8
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ctrlShadow_reg <= 8'h00;
    end else if (wbRsp.ack && wbReq.we && wbReq.adr == CTRL_OFFSET && wbReq.sel[1]) begin
      ctrlShadow_reg <= wbReq.dat[15:8] & 8'hbf;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  property p_oe_en; refClockOe == $past(shEn); endproperty
  property p_pin_off; !refClockOe |-> !refClockPin; endproperty
  property p_pass; (shEn && ctrlShadow_reg[3:0] == 4'h0 && !sleepRequest)[*4] |-> refClockPin == $past(baseLevel, 2);
  endproperty
  property p_rsvd; wbRsp.ack && !wbReq.we && wbReq.adr == CTRL_OFFSET |-> (wbRsp.dat & 32'hffff40ff) == 32'h0;
  endproperty
  property p_rst; $past(sys_rst) |-> !refClockOe && !refClockPin && !wbRsp.ack; endproperty
  property p_stop; (sleepRequest && !ctrlShadow_reg[5])[*3] |-> !refClockPin; endproperty
  property p_nprim; (sleepRequest && oscConfig > 3'h2)[*3] |-> !refClockPin && !primaryOscEnable; endproperty
  property p_pdown; (sleepRequest && !ctrlShadow_reg[4])[*3] |-> !primaryOscEnable; endproperty
  property p_posc; (!sleepRequest && $stable(oscConfig))[*3] |-> primaryOscEnable == (oscConfig <= 3'h2); endproperty
  a_oe_en: assert property (p_oe_en) else $error("oe differs from enable");
  a_pin_off: assert property (p_pin_off) else $error("pin high while disabled");
  a_pass: assert property (p_pass) else $error("undivided pin wrong");
  a_rsvd: assert property (p_rsvd) else $error("unused control bits read high");
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
  a_stop: assert property (p_stop) else $error("pin runs in sleep");
  a_nprim: assert property (p_nprim) else $error("non-primary sleep keeps output");
  a_pdown: assert property (p_pdown) else $error("primary kept in sleep");
  a_posc: assert property (p_posc) else $error("primary enable wrong awake");
  c_sleep_run: cover property (sleepRequest && refClockPin);
  c_write: cover property (wbRsp.ack && wbReq.we);
  c_div: cover property (refClockOe && ctrlShadow_reg[3:0] != 4'h0);
endmodule // rcd_ref_clock_out_props

// file: rcd_ref_sink.sv
`timescale 1ns/100ps
module rcd_ref_sink (
  // clock
  input  wire logic ref_clk,
  // reference pin as the load sees it
  input  wire logic refClockPin,
  input  wire logic refClockOe,
  // period in clock cycles and rising-edge count
  output int        period,
  output int        edges
);
  logic seen;
  logic lastLevel;
  int   age;
  // undriven pin is pulled low
  assign seen = refClockOe & refClockPin;
  initial begin
    period = 0;
    edges = 0;
    age = 0;
    lastLevel = 1'b0;
  end
  always @(posedge ref_clk) begin
    lastLevel <= seen;
    age <= age + 1;
    if (seen && !lastLevel) begin
      edges <= edges + 1;
      period <= age + 1;
      age <= 0;
    end
  end
endmodule // rcd_ref_sink

// file: test_rcd_ref_clock_out.sv
`timescale 1ns/100ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin error_cnt++; $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module test_rcd_ref_clock_out;
  import rcd_pkg::*;
  logic        ref_clk, sys_rst, sysClkLevel, primaryClkLevel, sleepRequest;
  logic        refClockPin, refClockOe, primaryOscEnable;
  logic [2:0]  oscConfig;
  logic [15:0] lfsr, rd;
  rcd_wb_req_t wbReq;
  rcd_wb_rsp_t wbRsp;
  int          error_cnt, compares, period, edges, sysHalf, primHalf, cnt, s0;
  rcd_ref_clock_out dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .wbReq(wbReq), .wbRsp(wbRsp),
    .sysClkLevel(sysClkLevel), .primaryClkLevel(primaryClkLevel), .sleepRequest(sleepRequest),
    .oscConfig(oscConfig), .refClockPin(refClockPin), .refClockOe(refClockOe), .primaryOscEnable(primaryOscEnable));
  rcd_ref_sink load (.ref_clk(ref_clk), .refClockPin(refClockPin), .refClockOe(refClockOe),
    .period(period), .edges(edges));
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // base clocks with adjustable half periods
  always @(posedge ref_clk) begin
    cnt <= cnt + 1;
    if (cnt % sysHalf == 0) sysClkLevel <= ~sysClkLevel;
    if (cnt % primHalf == 0) primaryClkLevel <= ~primaryClkLevel;
  end
  function automatic logic [15:0] next_lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task final_report;
    if (error_cnt == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task wb(input logic we, input logic [7:0] adr, input logic [15:0] dat, output logic [15:0] q);
    int i;
    @(posedge ref_clk);
    wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: adr, dat: {16'h0, dat}};
    i = 0;
    do begin
      @(posedge ref_clk);
      i++;
    end while (wbRsp.ack !== 1'b1 && i < 50);
    q = wbRsp.dat[15:0];
    wbReq <= '0;
    if (i >= 50) begin error_cnt++; final_report; end
  endtask
  task wait_edges(input int n);
    int s, i;
    s = edges;
    i = 0;
    while (edges < s + n && i < 3000) begin @(posedge ref_clk); i++; end
    if (i >= 3000) begin error_cnt++; final_report; end
  endtask
  initial begin
    sys_rst = 1'b1; wbReq = '0; sleepRequest = 1'b0; oscConfig = STANDARD_CRYSTAL_MODE;
    sysClkLevel = 1'b0; primaryClkLevel = 1'b0; cnt = 0; sysHalf = 2; primHalf = 3;
    lfsr = 16'h001f; error_cnt = 0; compares = 0;
    repeat (8) @(posedge ref_clk);
    sys_rst <= 1'b0;
    wb(1'b0, CTRL_OFFSET, 16'h0000, rd); `CHK(rd, CTRL_RESET)
    repeat (6) begin
      lfsr = next_lfsr(lfsr);
      wb(1'b1, CTRL_OFFSET, lfsr, rd);
      wb(1'b0, CTRL_OFFSET, 16'h0000, rd); `CHK(rd, lfsr & CTRL_WRITE_MASK)
    end
    wb(1'b0, 8'h08, 16'h0000, rd); `CHK(rd, 16'h0000)
    wb(1'b1, CTRL_OFFSET, 16'h8000, rd); wait_edges(3); `CHK(period, 2 * sysHalf)
    for (int k = 0; k < 8; k++) begin
      if (k == 4) sysHalf <= 5;
      wb(1'b1, CTRL_OFFSET, 16'h8000 | (16'(k[0]) << 12) | (16'(1 + (k >> 1)) << 8), rd);
      wait_edges(3);
      `CHK(period, (k[0] ? 2 * primHalf : 2 * sysHalf) << (1 + (k >> 1)))
    end
    wb(1'b1, CTRL_OFFSET, 16'h0000, rd); repeat (3) @(posedge ref_clk);
    `CHK({refClockOe, refClockPin}, 2'b00)
    wb(1'b1, CTRL_OFFSET, 16'hb100, rd); sleepRequest <= 1'b1;
    wait_edges(3); `CHK(period, 4 * primHalf)
    `CHK(primaryOscEnable, 1'b1)
    wb(1'b0, STATUS_OFFSET, 16'h0000, rd); `CHK(rd & 16'hfffd, 16'h003d)
    wb(1'b1, CTRL_OFFSET, 16'h9100, rd); repeat (3) @(posedge ref_clk);
    s0 = edges; repeat (100) @(posedge ref_clk); `CHK(edges - s0, 0)
    wb(1'b1, CTRL_OFFSET, 16'ha100, rd); repeat (3) @(posedge ref_clk);
    `CHK(primaryOscEnable, 1'b0)
    sleepRequest <= 1'b0; oscConfig <= 3'h5;
    wb(1'b1, CTRL_OFFSET, 16'h8200, rd); wait_edges(3); `CHK(period, 8 * sysHalf)
    `CHK(primaryOscEnable, 1'b0)
    oscConfig <= EXTERNAL_CLOCK_MODE; repeat (3) @(posedge ref_clk); `CHK(primaryOscEnable, 1'b1)
    oscConfig <= HIGH_SPEED_CRYSTAL_MODE; repeat (3) @(posedge ref_clk); `CHK(primaryOscEnable, 1'b1)
    oscConfig <= 3'h5; sleepRequest <= 1'b1; repeat (4) @(posedge ref_clk);
    s0 = edges; repeat (60) @(posedge ref_clk); `CHK(edges - s0, 0)
    `CHK(primaryOscEnable, 1'b0)
    final_report;
  end
endmodule // test_rcd_ref_clock_out
bind rcd_ref_clock_out rcd_ref_clock_out_props u_props (.ref_clk(ref_clk), .sys_rst(sys_rst), .wbReq(wbReq),
  .wbRsp(wbRsp), .sysClkLevel(sysClkLevel), .primaryClkLevel(primaryClkLevel), .sleepRequest(sleepRequest),
  .oscConfig(oscConfig), .refClockPin(refClockPin), .refClockOe(refClockOe), .primaryOscEnable(primaryOscEnable));
